/* File: logic/interval_timer_pkg.sv */
// constants and types shared by the interval timer design
// assumes a byte-wide i/o port bus decoded on the low two address bits
package interval_timer_pkg;
  localparam logic [7:0] port_counter0 = 8'h40;
  localparam logic [7:0] port_counter1 = 8'h41;
  localparam logic [7:0] port_counter2 = 8'h42;
  localparam logic [7:0] port_control = 8'h43;
  localparam logic [1:0] sel_readback = 2'h3;
  localparam logic [1:0] acc_latch = 2'h0;
  localparam logic [1:0] acc_lsb = 2'h1;
  localparam logic [1:0] acc_msb = 2'h2;
  localparam logic [1:0] acc_both = 2'h3;
  localparam logic [2:0] mode_int_tc = 3'h0;
  localparam logic [2:0] mode_one_shot = 3'h1;
  localparam logic [2:0] mode_rate = 3'h2;
  localparam logic [2:0] mode_square = 3'h3;
  localparam logic [2:0] mode_sw_strobe = 3'h4;
  localparam logic [2:0] mode_hw_strobe = 3'h5;
  localparam logic [15:0] count_max_bin = 16'hffff;
  localparam logic [15:0] count_max_bcd = 16'h9999;
  localparam logic [3:0] bcd_nine = 4'h9;
  // count clock and system clock in hz
  localparam int count_clock_hz = 1193000;
  localparam int sys_clock_hz = 25000000;
  localparam logic [31:0] tick_step = 32'(count_clock_hz);
  localparam logic [31:0] tick_wrap = 32'(sys_clock_hz);

  typedef struct packed {
    logic [1:0] access;
    logic [2:0] mode;
    logic bcd;
  } counter_cfg_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } io_req_t;
endpackage

/* File: logic/interval_timer.sv */
// three 16-bit interval counters behind byte-wide i/o ports 40h..43h
// assumes host strobes are single cycle and synchronous to clk_sys
`timescale 1ns/1ps
module interval_timer (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [7:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic speaker_enable,
  output logic [7:0] io_rdata,
  output logic timer_interrupt_request,
  output logic refresh_counter_output,
  output logic tone_counter_output
);
  interval_timer_pkg::io_req_t req;
  assign req = '{addr: io_addr, wdata: io_wdata, wr: io_wr, rd: io_rd};

  // speaker enable is an outside pin: three stages, change taken when last two agree
  logic [2:0] spk_sync_reg;
  logic spk_level_reg;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      spk_sync_reg <= 3'h0;
      spk_level_reg <= 1'b0;
    end else begin
      spk_sync_reg <= {spk_sync_reg[1:0], speaker_enable};
      if (spk_sync_reg[2] == spk_sync_reg[1]) begin
        spk_level_reg <= spk_sync_reg[2];
      end
    end
  end

  // fractional divider makes one count tick per 1.193 mhz period
  logic [31:0] phase_reg;
  logic tick_reg;
  wire [31:0] phase_sum = phase_reg + interval_timer_pkg::tick_step;
  wire phase_over = phase_sum >= interval_timer_pkg::tick_wrap;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      phase_reg <= 32'h0;
      tick_reg <= 1'b0;
    end else begin
      phase_reg <= phase_over ? phase_sum - interval_timer_pkg::tick_wrap : phase_sum;
      tick_reg <= phase_over;
    end
  end

  // address decode
  wire sel_port = req.addr[7:2] == interval_timer_pkg::port_counter0[7:2];
  wire ctl_wr = req.wr && req.addr == interval_timer_pkg::port_control;
  wire [1:0] ctl_sel = req.wdata[7:6];
  wire is_readback = ctl_wr && ctl_sel == interval_timer_pkg::sel_readback;
  wire is_latch = ctl_wr && !is_readback && req.wdata[5:4] == interval_timer_pkg::acc_latch;
  wire [2:0] gate_in = {spk_level_reg, 1'b1, 1'b1};
  wire [2:0] out_vec;
  wire [7:0] rd_vec [3];

  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_ctr
      wire data_sel = sel_port && req.addr[1:0] == 2'(i);
      wire data_wr = req.wr && data_sel;
      wire data_rd = req.rd && data_sel;
      wire prog_wr = ctl_wr && !is_readback && !is_latch && ctl_sel == 2'(i);
      wire latch_cmd = (is_latch && ctl_sel == 2'(i))
                       || (is_readback && !req.wdata[5] && req.wdata[i + 1]);
      wire status_cmd = is_readback && !req.wdata[4] && req.wdata[i + 1];

      interval_timer_pkg::counter_cfg_t cfg_reg;
      logic [15:0] ce_reg;
      logic [15:0] init_reg;
      logic [15:0] ol_reg;
      logic [7:0] status_reg;
      logic [7:0] lsb_hold_reg;
      logic ol_valid_reg;
      logic st_valid_reg;
      logic wr_msb_reg;
      logic rd_msb_reg;
      logic null_reg;
      logic load_pend_reg;
      logic armed_reg;
      logic out_reg;
      logic gate_d_reg;
      logic trig_reg;

      wire [2:0] mode_ctl = req.wdata[3:1];
      // x10 and x11 fold to modes 2 and 3
      wire [2:0] mode_dec = mode_ctl[1] ? {1'b0, mode_ctl[1:0]} : mode_ctl;
      wire gate = gate_in[i];
      wire gate_rise = gate && !gate_d_reg;

      // decrement by one or two, with bcd digit borrow
      function automatic logic [15:0] dec_by(input logic [15:0] v, input logic bcd, input logic two);
        logic [15:0] r;
        logic [4:0] d;
        logic borrow;
        r = v;
        borrow = 1'b0;
        if (!bcd) begin
          r = v - (two ? 16'h2 : 16'h1);
        end else begin
          for (int k = 0; k < 4; k++) begin
            d = {1'b0, v[k*4 +: 4]} - ((k == 0) ? (two ? 5'h2 : 5'h1) : 5'h0) - {4'h0, borrow};
            borrow = d[4];
            r[k*4 +: 4] = borrow ? 4'(d[3:0] + 4'ha) : d[3:0];
          end
        end
        return r;
      endfunction

      wire is_square = cfg_reg.mode == interval_timer_pkg::mode_square;
      wire counts = gate || cfg_reg.mode == interval_timer_pkg::mode_one_shot
                    || cfg_reg.mode == interval_timer_pkg::mode_hw_strobe;
      wire [15:0] ce_dec = dec_by(ce_reg, cfg_reg.bcd, is_square && !ce_reg[0]);
      wire ce_one = ce_reg == 16'h1;
      wire ce_two = ce_reg == 16'h2;
      wire [15:0] latch_src = ce_reg;
      wire [7:0] status_now = {out_reg, null_reg, cfg_reg};
      // count byte on read, per programmed format
      wire [7:0] count_byte = (cfg_reg.access == interval_timer_pkg::acc_msb
                               || (cfg_reg.access == interval_timer_pkg::acc_both && rd_msb_reg))
                              ? ol_reg[15:8] : ol_reg[7:0];
      wire [15:0] rd_src_unused = ol_valid_reg ? ol_reg : ce_reg;
      wire [7:0] live_byte = (cfg_reg.access == interval_timer_pkg::acc_msb
                              || (cfg_reg.access == interval_timer_pkg::acc_both && rd_msb_reg))
                             ? rd_src_unused[15:8] : rd_src_unused[7:0];
      assign rd_vec[i] = st_valid_reg ? status_reg : (ol_valid_reg ? count_byte : live_byte);
      wire count_done = cfg_reg.access != interval_timer_pkg::acc_both || rd_msb_reg;

      // completed initial count from the host bytes
      wire [15:0] new_init = (cfg_reg.access == interval_timer_pkg::acc_lsb) ? {8'h0, req.wdata}
                           : (cfg_reg.access == interval_timer_pkg::acc_msb) ? {req.wdata, 8'h0}
                           : {req.wdata, lsb_hold_reg};
      wire init_done = data_wr && (cfg_reg.access != interval_timer_pkg::acc_both || wr_msb_reg);
      // zero loads as maximum: one decrement wraps it
      wire [15:0] load_val = init_reg;
      wire load_now = tick_reg && load_pend_reg
                      && (cfg_reg.mode == interval_timer_pkg::mode_one_shot
                          || cfg_reg.mode == interval_timer_pkg::mode_hw_strobe ? trig_reg : 1'b1);
      wire reload = tick_reg && !load_pend_reg && armed_reg && counts
                    && ((cfg_reg.mode == interval_timer_pkg::mode_rate && ce_one)
                        || (is_square && (ce_two || (ce_one && ce_reg[0]))));
      wire retrig = tick_reg && trig_reg && !load_pend_reg && armed_reg
                    && (cfg_reg.mode == interval_timer_pkg::mode_one_shot
                        || cfg_reg.mode == interval_timer_pkg::mode_hw_strobe);

      always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
          cfg_reg <= '{access: interval_timer_pkg::acc_lsb, mode: interval_timer_pkg::mode_int_tc, bcd: 1'b0};
          ce_reg <= 16'h0;
          init_reg <= 16'h0;
          ol_reg <= 16'h0;
          status_reg <= 8'h0;
          lsb_hold_reg <= 8'h0;
          ol_valid_reg <= 1'b0;
          st_valid_reg <= 1'b0;
          wr_msb_reg <= 1'b0;
          rd_msb_reg <= 1'b0;
          null_reg <= 1'b1;
          load_pend_reg <= 1'b0;
          armed_reg <= 1'b0;
          out_reg <= 1'b0;
          // tied gates idle high, so no false trigger edge follows reset
          gate_d_reg <= 1'(i < 2);
          trig_reg <= 1'b0;
        end else begin
          gate_d_reg <= gate;
          if (gate_rise) begin
            trig_reg <= 1'b1;
          end else if (tick_reg) begin
            trig_reg <= 1'b0;
          end
          if (prog_wr) begin
            cfg_reg <= '{access: req.wdata[5:4], mode: mode_dec, bcd: req.wdata[0]};
            null_reg <= 1'b1;
            ol_valid_reg <= 1'b0;
            st_valid_reg <= 1'b0;
            wr_msb_reg <= 1'b0;
            rd_msb_reg <= 1'b0;
            armed_reg <= 1'b0;
            load_pend_reg <= 1'b0;
            // mode 0 starts low, all others idle high
            out_reg <= mode_dec != interval_timer_pkg::mode_int_tc;
          end else begin
            if (latch_cmd && !ol_valid_reg) begin
              ol_reg <= latch_src;
              ol_valid_reg <= 1'b1;
              rd_msb_reg <= 1'b0;
            end
            if (status_cmd && !st_valid_reg) begin
              status_reg <= status_now;
              st_valid_reg <= 1'b1;
            end
            if (data_rd) begin
              if (st_valid_reg) begin
                st_valid_reg <= 1'b0;
              end else begin
                rd_msb_reg <= cfg_reg.access == interval_timer_pkg::acc_both && !rd_msb_reg;
                if (count_done) begin
                  ol_valid_reg <= 1'b0;
                end
              end
            end
            if (data_wr) begin
              if (cfg_reg.access == interval_timer_pkg::acc_both && !wr_msb_reg) begin
                lsb_hold_reg <= req.wdata;
                wr_msb_reg <= 1'b1;
                // mode 0 drops output on first byte
                if (cfg_reg.mode == interval_timer_pkg::mode_int_tc) begin
                  out_reg <= 1'b0;
                end
              end else begin
                wr_msb_reg <= 1'b0;
              end
              null_reg <= 1'b1;
            end
            if (init_done) begin
              init_reg <= new_init;
              load_pend_reg <= 1'b1;
              if (cfg_reg.mode == interval_timer_pkg::mode_int_tc) begin
                out_reg <= 1'b0;
              end
            end else if (load_now || reload || retrig) begin
              ce_reg <= load_val;
              load_pend_reg <= 1'b0;
              armed_reg <= 1'b1;
              // a byte written in the load cycle keeps null set
              if (load_now && !data_wr) begin
                null_reg <= 1'b0;
              end
              if (cfg_reg.mode == interval_timer_pkg::mode_one_shot) begin
                out_reg <= 1'b0;
              end else if (cfg_reg.mode == interval_timer_pkg::mode_rate) begin
                out_reg <= 1'b1;
              end else if (is_square && !load_now) begin
                out_reg <= !out_reg;
              end
            end else if (tick_reg && armed_reg && counts) begin
              ce_reg <= ce_dec;
              unique case (cfg_reg.mode)
                interval_timer_pkg::mode_int_tc,
                interval_timer_pkg::mode_one_shot: begin
                  if (ce_one) begin
                    out_reg <= 1'b1;
                  end
                end
                interval_timer_pkg::mode_rate: begin
                  out_reg <= !ce_two;
                end
                interval_timer_pkg::mode_square: begin
                  out_reg <= out_reg;
                end
                interval_timer_pkg::mode_sw_strobe,
                interval_timer_pkg::mode_hw_strobe: begin
                  out_reg <= !ce_one;
                end
                default: begin
                  out_reg <= out_reg;
                end
              endcase
            end
            if (!gate && (cfg_reg.mode == interval_timer_pkg::mode_rate || is_square)) begin
              out_reg <= 1'b1;
            end
          end
        end
      end
      assign out_vec[i] = out_reg;
    end
  endgenerate

  // read data is registered; control port reads back zero
  wire [7:0] rd_sel = (sel_port && req.addr[1:0] != 2'h3) ? rd_vec[req.addr[1:0]] : 8'h0;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      io_rdata <= 8'h0;
      timer_interrupt_request <= 1'b0;
      refresh_counter_output <= 1'b0;
      tone_counter_output <= 1'b0;
    end else begin
      io_rdata <= req.rd ? rd_sel : 8'h0;
      timer_interrupt_request <= out_vec[0];
      refresh_counter_output <= out_vec[1];
      tone_counter_output <= out_vec[2];
    end
  end
endmodule

/* File: tb/interval_timer_props.sv */
// checker on the interval timer ports
// assumes one clock domain, attached by the bind below
`timescale 1ns/1ps
module interval_timer_props (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [7:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic speaker_enable,
  input wire logic [7:0] io_rdata,
  input wire logic timer_interrupt_request,
  input wire logic refresh_counter_output,
  input wire logic tone_counter_output
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  wire cw_wr = io_wr && io_addr == interval_timer_pkg::port_control;
  wire rd_c0 = io_rd && io_addr == interval_timer_pkg::port_counter0;
  reset_quiet_a: assert property ($past(sys_rst) |-> io_rdata == 8'h00 && !timer_interrupt_request
    && !refresh_counter_output && !tone_counter_output) else $error("outputs busy after reset");
  rdata_idle_a: assert property (!$past(io_rd) |-> io_rdata == 8'h00)
    else $error("read data without a read");
  ctrl_read_a: assert property (io_rd && io_addr == interval_timer_pkg::port_control
    |=> io_rdata == 8'h00) else $error("control port answered");
  unmapped_read_a: assert property (io_rd && io_addr[7:2] != 6'h10 |=> io_rdata == 8'h00)
    else $error("unmapped port answered");
  mode0_low_a: assert property (cw_wr && io_wdata[7:6] == 2'h0 && io_wdata[5:4] != 2'h0
    && io_wdata[3:1] == 3'h0 |-> ##[1:3] !timer_interrupt_request) else $error("mode 0 output not low");
  // status read follows the read-back write by two cycles in our host
  status_first_a: assert property (cw_wr && io_wdata[7:6] == 2'h3 && !io_wdata[4] && io_wdata[1]
    && !io_wdata[0] ##[1:2] rd_c0 |=> io_rdata[5:4] != 2'h0) else $error("status byte format");
  irq_hold_a: assert property ($rose(timer_interrupt_request) ##1 (!io_wr) [*6]
    |-> timer_interrupt_request) else $error("interrupt output glitched");
  refresh_hold_a: assert property ($fell(refresh_counter_output) ##1 (!io_wr) [*6]
    |-> !refresh_counter_output) else $error("refresh output glitched");
  cover property (cw_wr && io_wdata[7:6] == 2'h3);
  cover property ($rose(timer_interrupt_request));
  cover property ($rose(tone_counter_output));
endmodule
bind interval_timer interval_timer_props u_props (.clk_sys, .sys_rst, .io_addr, .io_wdata, .io_wr, .io_rd,
  .speaker_enable, .io_rdata, .timer_interrupt_request, .refresh_counter_output, .tone_counter_output);

/* File: tb/host_port_model.sv */
// host side of the byte-wide port bus
// assumes read data answers one cycle after the read strobe
`timescale 1ns/1ps
module host_port_model (
  input wire logic clk_sys,
  input wire logic [7:0] io_rdata,
  output interval_timer_pkg::io_req_t req
);
  initial req = '{addr: 8'h00, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
  // idle lines inverted so a stale byte never passes for a request
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    req <= '{addr: a, wdata: 8'h5a, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    req <= '{addr: ~a, wdata: 8'ha5, wr: 1'b0, rd: 1'b0};
    @(negedge clk_sys);
    d = io_rdata;
  endtask
endmodule

/* File: tb/test_three_counter_interval_timer.sv */
// self-checking bench for the interval timer
// assumes the host model and the bound checker are compiled first
`timescale 1ns/1ps
module test_three_counter_interval_timer;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic speaker_enable = 1'b0;
  logic [7:0] io_rdata;
  logic timer_interrupt_request;
  logic refresh_counter_output;
  logic tone_counter_output;
  interval_timer_pkg::io_req_t req;
  int err_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int seed = 32'h2f44;
  int t;
  logic [7:0] b;
  logic [7:0] c;
  logic [15:0] v;
  logic [15:0] w;
  logic [15:0] cnt;
  always #20 clk_sys = ~clk_sys;
  host_port_model u_host (.clk_sys, .io_rdata, .req);
  interval_timer u_dut (.clk_sys, .sys_rst, .io_addr(req.addr), .io_wdata(req.wdata), .io_wr(req.wr),
    .io_rd(req.rd), .speaker_enable, .io_rdata, .timer_interrupt_request, .refresh_counter_output,
    .tone_counter_output);
  function automatic logic [7:0] exp_status(logic [1:0] acc, logic [2:0] m, logic bcd, logic nul);
    return {1'b0, nul, acc, (m[1] ? {1'b0, m[1:0]} : m), bcd};
  endfunction
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic ok, input string what);
    comparisons++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask
  task automatic rd16(input logic [7:0] p, output logic [15:0] r);
    logic [7:0] lo;
    logic [7:0] hi;
    u_host.rd(p, lo);
    u_host.rd(p, hi);
    r = {hi, lo};
  endtask
  // poll status until the count reaches the counting element
  task automatic wait_load(input int n);
    logic [7:0] s;
    s = 8'hff;
    for (int i = 0; i < 20 && s[6] === 1'b1; i++) begin
      u_host.wr(8'h43, 8'he0 | (8'h02 << n));
      u_host.rd(8'h40 + 8'(n), s);
    end
    chk(s[6] === 1'b0, "null count stuck");
  endtask
  task automatic load(input int n, input logic [7:0] cw, input logic [15:0] cv);
    u_host.wr(8'h43, cw);
    u_host.wr(8'h40 + 8'(n), cv[7:0]);
    u_host.wr(8'h40 + 8'(n), cv[15:8]);
    wait_load(n);
  endtask
  task automatic count_tone(output int n);
    logic last;
    n = 0;
    last = tone_counter_output;
    repeat (300) begin
      @(negedge clk_sys);
      if (tone_counter_output !== last) n++;
      last = tone_counter_output;
    end
  endtask
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      err_count++;
      $display("wrong value at %0t: run timed out", $time);
      test_done;
    end
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    u_host.rd(8'h43, b);
    chk(b === 8'h00, "control port read");
    u_host.rd(8'h44, b);
    chk(b === 8'h00, "unmapped read");
    for (int n = 0; n < 3; n++) begin
      u_host.wr(8'h43, 8'he0 | (8'h02 << n));
      u_host.rd(8'h40 + 8'(n), b);
      chk((b & 8'h7f) === exp_status(2'h1, 3'h0, 1'b0, 1'b1), "reset status");
    end
    // every format and mode code, aliases of modes 2 and 3 too, random bcd
    for (int k = 0; k < 18; k++) begin
      c = {2'(k % 3), 2'((k / 3) % 3 + 1), 3'(k), 1'($random(seed))};
      u_host.wr(8'h43, c);
      u_host.wr(8'h43, 8'he0 | (8'h02 << (k % 3)));
      u_host.rd(8'h40 + 8'(k % 3), b);
      chk((b & 8'h7f) === exp_status(c[5:4], c[3:1], c[0], 1'b1), "status fields");
    end
    cnt = 16'h0010 | 16'($random(seed) & 32'h0f);
    load(1, 8'h74, cnt);
    chk(refresh_counter_output === 1'b1, "refresh output idles high");
    u_host.wr(8'h43, 8'h40);
    repeat (100) @(posedge clk_sys);
    u_host.wr(8'h43, 8'h40);
    rd16(8'h41, v);
    chk(v <= cnt && v + 16'h0004 > cnt, "first latch kept");
    u_host.wr(8'h43, 8'h40);
    rd16(8'h41, w);
    chk(w < v, "latch follows count again");
    u_host.wr(8'h43, 8'hc4);
    u_host.rd(8'h41, b);
    chk((b & 8'h7f) === exp_status(2'h3, 3'h2, 1'b0, 1'b0), "status first");
    rd16(8'h41, v);
    chk(v <= w, "count after status");
    load(0, 8'h30, 16'h0200);
    chk(timer_interrupt_request === 1'b0, "mode 0 output low");
    u_host.wr(8'h40, 8'h03);
    u_host.wr(8'h40, 8'h00);
    for (int i = 0; i < 200 && timer_interrupt_request !== 1'b1; i++) @(posedge clk_sys);
    chk(timer_interrupt_request === 1'b1, "terminal count interrupt");
    repeat (10) @(posedge clk_sys);
    // zero count in binary and bcd
    for (int k = 0; k < 2; k++) begin
      load(0, 8'h34 | 8'(k), 16'h0000);
      repeat (100) @(posedge clk_sys);
      u_host.wr(8'h43, 8'h00);
      rd16(8'h40, v);
      chk(v[15:8] === (k ? 8'h99 : 8'hff) && v[3:0] <= (k ? 4'h9 : 4'hf), "zero as maximum");
    end
    @(posedge clk_sys) speaker_enable <= 1'b1;
    load(2, 8'hb6, 16'h0004);
    count_tone(t);
    chk(t >= 4, "tone runs with speaker on");
    @(posedge clk_sys) speaker_enable <= 1'b0;
    repeat (8) @(posedge clk_sys);
    count_tone(t);
    chk(t <= 1, "tone stops with speaker off");
    test_done;
  end
endmodule
